// File: sstc_pkg.sv
// Behaviour
// R1: every table entry is a 16-bit word
// R2: words 1 to 11 hold controller status; word 2 reads zero here
// R3: words 12-15 module health, 16-181 unused
// R4: words 182-184 global health, table 184 words
// R5: bit 1 is msb, bit 16 lsb
// R6: copy word 1 onward into consecutive registers
// R7: requester gives word count 1 to 184
// R8: bit 6 set when constant sweep enabled
// R9: bit 7 single sweep unless stopped
// R10: bits 8-12 node, power, run, protect, battery
// R11: done flag after copy; unused reads zero
`default_nettype none
package sstc_pkg;
  // table geometry
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned TABLE_WORDS = 184;
  localparam int unsigned IDX_W       = 8;
  localparam int unsigned DEST_W      = 16;
  localparam logic [IDX_W-1:0] CTRL_FIRST   = 8'h01;
  localparam logic [IDX_W-1:0] CTRL_LAST    = 8'h0B;
  localparam logic [IDX_W-1:0] HEALTH_FIRST = 8'h0C;
  localparam logic [IDX_W-1:0] HEALTH_LAST  = 8'h0F;
  localparam logic [IDX_W-1:0] GLOBAL_FIRST = 8'hB6;
  localparam logic [IDX_W-1:0] GLOBAL_LAST  = 8'hB8;
  localparam logic [IDX_W-1:0] COUNT_MIN    = 8'h01;
  localparam logic [IDX_W-1:0] COUNT_MAX    = 8'hB8;
  // documented bit numbers, 1 = msb
  localparam int unsigned BIT_CONST_SWEEP = 6;
  localparam int unsigned BIT_SINGLE      = 7;
  localparam int unsigned BIT_SMALL_NODE  = 8;
  localparam int unsigned BIT_POWER_ON    = 9;
  localparam int unsigned BIT_RUN_OFF     = 10;
  localparam int unsigned BIT_PROT_OFF    = 11;
  localparam int unsigned BIT_BATT_BAD    = 12;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  // copier states
  typedef enum logic [2:0] {
    SSTC_IDLE = 3'b001,
    SSTC_COPY = 3'b010,
    SSTC_DONE = 3'b100
  } sstc_state_e;
  // map documented bit number to vector index
  function automatic int unsigned sstc_pos(input int unsigned n);
    return WORD_W - n;
  endfunction
endpackage
`default_nettype wire

// File: sstc_tbl_if.sv
`timescale 1ns/10ps
`default_nettype none
// table lookup between copier and status source
interface sstc_tbl_if;
  import sstc_pkg::*;
  logic [IDX_W-1:0]  idx;   // 1-based word number
  logic [WORD_W-1:0] word;  // word contents
  modport copier (output idx, input word);
  modport table_src (input idx, output word);
endinterface
`default_nettype wire

// File: sstc_table.sv
`timescale 1ns/10ps
`default_nettype none
module sstc_table
  import sstc_pkg::*;
(
  // lookup
  sstc_tbl_if.table_src                        tbl,
  // controller conditions
  input  wire logic                            const_sweep_en,
  input  wire logic                            single_sweep_en,
  input  wire logic                            stop_state,
  input  wire logic                            small_nodes,
  input  wire logic                            power_ok,
  input  wire logic                            running,
  input  wire logic                            mem_protect_on,
  input  wire logic                            battery_ok,
  // other status sources
  input  wire logic [4*sstc_pkg::WORD_W-1:0]   io_health,
  input  wire logic [3*sstc_pkg::WORD_W-1:0]   global_health,
  input  wire logic [10*sstc_pkg::WORD_W-1:0]  ctrl_other
);
  import sstc_pkg::*;

  logic [WORD_W-1:0] cpu_status_word;  // word 1
  logic [WORD_W-1:0] rd;
  logic [IDX_W-1:0]  i;
  // word 1 assembled bit by bit, bit 1 at msb
  always_comb begin
    cpu_status_word = WORD_RESET;                                              // R11
    cpu_status_word[sstc_pos(BIT_CONST_SWEEP)] = const_sweep_en;               // R8
    cpu_status_word[sstc_pos(BIT_SINGLE)] = single_sweep_en & ~stop_state;     // R9
    cpu_status_word[sstc_pos(BIT_SMALL_NODE)] = small_nodes;                   // R10
    cpu_status_word[sstc_pos(BIT_POWER_ON)] = power_ok;                        // R10
    cpu_status_word[sstc_pos(BIT_RUN_OFF)] = ~running;                         // R10
    cpu_status_word[sstc_pos(BIT_PROT_OFF)] = ~mem_protect_on;                 // R10
    cpu_status_word[sstc_pos(BIT_BATT_BAD)] = ~battery_ok;                     // R10, R5
  end
  assign i = tbl.idx;
  // region select; word 2 and 16-181 read zero
  always_comb begin
    rd = WORD_RESET;                                                           // R11, R3
    if (i == CTRL_FIRST) begin
      rd = cpu_status_word;                                                    // R2
    end else if (i >= 8'h03 && i <= CTRL_LAST) begin
      rd = ctrl_other[(i - 8'h02) * WORD_W +: WORD_W];                         // R2
    end else if (i >= HEALTH_FIRST && i <= HEALTH_LAST) begin
      rd = io_health[(i - HEALTH_FIRST) * WORD_W +: WORD_W];                   // R3
    end else if (i >= GLOBAL_FIRST && i <= GLOBAL_LAST) begin
      rd = global_health[(i - GLOBAL_FIRST) * WORD_W +: WORD_W];               // R4
    end
  end
  assign tbl.word = rd;                                                        // R1
endmodule
`default_nettype wire

// File: sstc_copier.sv
`timescale 1ns/10ps
`default_nettype none
module sstc_copier
  import sstc_pkg::*;
(
  // clocking
  input  wire logic                         mclk,
  input  wire logic                         reset,
  input  wire logic                         ce,
  // copy request
  input  wire logic                         req,
  input  wire logic [sstc_pkg::DEST_W-1:0]  dest_start,
  input  wire logic [sstc_pkg::IDX_W-1:0]   word_count,
  output logic                              busy,
  output logic                              done,
  // holding register write port
  output logic                              hold_we,
  output logic [sstc_pkg::DEST_W-1:0]       hold_addr,
  output logic [sstc_pkg::WORD_W-1:0]       hold_data,
  // controller conditions and other status sources
  input  wire logic                         const_sweep_en,
  input  wire logic                         single_sweep_en,
  input  wire logic                         stop_state,
  input  wire logic                         small_nodes,
  input  wire logic                         power_ok,
  input  wire logic                         running,
  input  wire logic                         mem_protect_on,
  input  wire logic                         battery_ok,
  input  wire logic [10*sstc_pkg::WORD_W-1:0] ctrl_other,
  input  wire logic [4*sstc_pkg::WORD_W-1:0]  io_health,
  input  wire logic [3*sstc_pkg::WORD_W-1:0]  global_health
);
  import sstc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  sstc_state_e       state_r, state_nxt;
  logic [IDX_W-1:0]  idx_r, idx_nxt;       // next table word, 1-based
  logic [IDX_W-1:0]  count_r;              // latched word count
  logic [DEST_W-1:0] dest_r;               // latched destination start
  logic              we_r;
  logic [DEST_W-1:0] addr_r;
  logic [WORD_W-1:0] data_r;
  logic [IDX_W-1:0]  count_ok;             // clamped count
  logic              last_word;
  sstc_tbl_if        tbl ();

  // table source
  sstc_table u_table (
    .tbl             (tbl),
    .const_sweep_en  (const_sweep_en),
    .single_sweep_en (single_sweep_en),
    .stop_state      (stop_state),
    .small_nodes     (small_nodes),
    .power_ok        (power_ok),
    .running         (running),
    .mem_protect_on  (mem_protect_on),
    .battery_ok      (battery_ok),
    .io_health       (io_health),
    .global_health   (global_health),
    .ctrl_other      (ctrl_other)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode
  // out-of-range counts are clamped so a bad request cannot run away
  assign count_ok = (word_count < COUNT_MIN) ? COUNT_MIN :
                    (word_count > COUNT_MAX) ? COUNT_MAX : word_count;          // R7
  assign last_word = (idx_r == count_r);
  assign tbl.idx   = idx_r;
  assign busy      = (state_r == SSTC_COPY);
  assign done      = (state_r == SSTC_DONE);                                   // R11
  assign hold_we   = we_r;
  assign hold_addr = addr_r;
  assign hold_data = data_r;

  // next state
  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    case (state_r)
      SSTC_IDLE: begin
        if (req) begin
          state_nxt = SSTC_COPY;
          idx_nxt   = CTRL_FIRST;                                              // R6
        end
      end
      SSTC_COPY: begin
        if (last_word) begin
          state_nxt = SSTC_DONE;
        end else begin
          idx_nxt = idx_r + 8'h01;                                             // R6
        end
      end
      SSTC_DONE: begin
        // done holds one cycle, then new requests are taken
        state_nxt = SSTC_IDLE;
      end
      default: begin
        state_nxt = SSTC_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, frozen while ce is low
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= SSTC_IDLE;
      idx_r   <= CTRL_FIRST;
      count_r <= COUNT_MIN;
      dest_r  <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
      if (state_r == SSTC_IDLE && req) begin
        count_r <= count_ok;
        dest_r  <= dest_start;
      end
    end
  end

  // write port: word n goes to dest + n - 1
  always_ff @(posedge mclk) begin
    if (reset) begin
      we_r   <= 1'b0;
      addr_r <= '0;
      data_r <= WORD_RESET;
    end else if (ce) begin
      we_r <= busy;                                                            // R6
      if (busy) begin
        addr_r <= dest_r + DEST_W'(idx_r - CTRL_FIRST);                        // R6
        data_r <= tbl.word;                                                    // R1
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_first_word;
    @(posedge mclk) disable iff (reset)
      (ce && state_r == SSTC_IDLE && req) ##1 ce |=> (hold_we && hold_addr == dest_r);
  endproperty
  a_first_word: assert property (p_first_word) else $error("first word misplaced"); // R6

  property p_done_after_last;
    @(posedge mclk) disable iff (reset)
      (ce && busy && last_word) |=> done;
  endproperty
  a_done_after_last: assert property (p_done_after_last) else $error("no done"); // R11

  property p_count_range;
    @(posedge mclk) disable iff (reset)
      busy |-> (count_r >= COUNT_MIN && count_r <= COUNT_MAX && idx_r <= count_r);
  endproperty
  a_count_range: assert property (p_count_range) else $error("count out of range"); // R7

  property p_bit6;
    @(posedge mclk) disable iff (reset)
      (busy && idx_r == CTRL_FIRST) |-> (tbl.word[10] == const_sweep_en);
  endproperty
  a_bit6: assert property (p_bit6) else $error("bit 6 wrong"); // R8

  property p_bit7;
    @(posedge mclk) disable iff (reset)
      (busy && idx_r == CTRL_FIRST) |-> (tbl.word[9] == (single_sweep_en && !stop_state));
  endproperty
  a_bit7: assert property (p_bit7) else $error("bit 7 wrong"); // R9

  property p_bits8_12;
    @(posedge mclk) disable iff (reset)
      (busy && idx_r == CTRL_FIRST) |->
        (tbl.word[8:4] == {small_nodes, power_ok, !running, !mem_protect_on, !battery_ok});
  endproperty
  a_bits8_12: assert property (p_bits8_12) else $error("bits 8-12 wrong"); // R10

  property p_unused_zero;
    @(posedge mclk) disable iff (reset)
      (busy && (idx_r == 8'h02 || (idx_r > HEALTH_LAST && idx_r < GLOBAL_FIRST)))
        |-> (tbl.word == WORD_RESET);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused word nonzero"); // R3

  property p_global;
    @(posedge mclk) disable iff (reset)
      (busy && idx_r == GLOBAL_LAST) |-> (tbl.word == global_health[3*WORD_W-1 -: WORD_W]);
  endproperty
  a_global: assert property (p_global) else $error("global word wrong"); // R4

  property p_io;
    @(posedge mclk) disable iff (reset)
      (busy && idx_r == HEALTH_FIRST) |-> (tbl.word == io_health[WORD_W-1:0]);
  endproperty
  a_io: assert property (p_io) else $error("io health wrong"); // R3

  property p_ctrl;
    @(posedge mclk) disable iff (reset)
      (busy && idx_r == CTRL_LAST) |-> (tbl.word == ctrl_other[10*WORD_W-1 -: WORD_W]);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("ctrl word wrong"); // R2

  property p_upper_zero;
    @(posedge mclk) disable iff (reset)
      (busy && idx_r == CTRL_FIRST) |-> (tbl.word[15:11] == 5'h00 && tbl.word[3:0] == 4'h0);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("word 1 unused bit set"); // R11, R5

  // a low enable must hold the copy exactly where it stands
  property p_freeze;
    @(posedge mclk) disable iff (reset)
      !ce |=> ($stable(state_r) && $stable(idx_r) && $stable(hold_we) && $stable(hold_addr));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with ce low"); // R6

  // completion is a single enabled cycle, never a level
  property p_done_pulse;
    @(posedge mclk) disable iff (reset)
      (ce && done) |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done held too long"); // R11
endmodule
`default_nettype wire

// File: system_status_table_copier_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, want) begin num_checks++; if ((got) !== (want)) begin fails++; \
  $display("[ERR] t=%0t got=%0h want=%0h", $time, (got), (want)); end end

module system_status_table_copier_test;
  import sstc_pkg::*;
  localparam int LIMIT = 2000;            // generous ceiling, run needs about 430
  logic                    mclk;          // 200 MHz
  logic                    reset;         // sync, active high
  logic                    ce;            // held high except in test_ce_freeze
  logic                    req;           // copy request
  logic [DEST_W-1:0]       dest_start;    // first holding register
  logic [IDX_W-1:0]        word_count;    // words to copy
  logic                    busy;          // copy in progress
  logic                    done;          // completion pulse
  logic                    hold_we;       // holding write strobe
  logic [DEST_W-1:0]       hold_addr;     // holding write address
  logic [WORD_W-1:0]       hold_data;     // holding write data
  logic [7:0]              cond;          // sweep, single, stop, node, power, run, protect, batt
  logic [10*WORD_W-1:0]    ctrl_other;    // words 3..11
  logic [4*WORD_W-1:0]     io_health;     // words 12..15
  logic [3*WORD_W-1:0]     global_health; // words 182..184
  int                      fails;         // mismatches
  int                      num_checks;    // comparisons made
  int                      cycles = 0;    // watchdog count

  ////////////////////////////////////////////////////////////////////////////////
  initial mclk = 1'b0;
  // half period of 2.5 ns
  always #2.5 mclk = ~mclk;

  sstc_copier dut (
    .mclk(mclk), .reset(reset), .ce(ce), .req(req), .dest_start(dest_start),
    .word_count(word_count), .busy(busy), .done(done), .hold_we(hold_we),
    .hold_addr(hold_addr), .hold_data(hold_data), .const_sweep_en(cond[7]),
    .single_sweep_en(cond[6]), .stop_state(cond[5]), .small_nodes(cond[4]),
    .power_ok(cond[3]), .running(cond[2]), .mem_protect_on(cond[1]),
    .battery_ok(cond[0]), .ctrl_other(ctrl_other), .io_health(io_health),
    .global_health(global_health)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // expected table entry, worked out from the input conditions
  function automatic logic [WORD_W-1:0] exp_word(input int n);
    logic [WORD_W-1:0] w;
    w = '0;
    if (n == 1) begin
      w[WORD_W-BIT_CONST_SWEEP] = cond[7];
      w[WORD_W-BIT_SINGLE]      = cond[6] & ~cond[5];
      w[WORD_W-BIT_SMALL_NODE]  = cond[4];
      w[WORD_W-BIT_POWER_ON]    = cond[3];
      w[WORD_W-BIT_RUN_OFF]     = ~cond[2];
      w[WORD_W-BIT_PROT_OFF]    = ~cond[1];
      w[WORD_W-BIT_BATT_BAD]    = ~cond[0];
    end else if (n >= 3 && n <= 11) begin
      w = ctrl_other[(n-2)*WORD_W +: WORD_W];
    end else if (n >= 12 && n <= 15) begin
      w = io_health[(n-12)*WORD_W +: WORD_W];
    end else if (n >= 182 && n <= 184) begin
      w = global_health[(n-182)*WORD_W +: WORD_W];
    end
    return w;
  endfunction

  // one copy: request, then follow every write up to the end pulse
  task automatic run_copy(input logic [DEST_W-1:0] dest, input logic [IDX_W-1:0] cnt,
                          input int exp_n);
    int n;
    int k;
    n = 0;
    @(posedge mclk);
    req        <= 1'b1;
    dest_start <= dest;
    word_count <= cnt;
    @(posedge mclk);
    req <= 1'b0;
    for (k = 0; k < exp_n + 8 && n < exp_n; k++) begin
      @(posedge mclk);
      #1;
      if (hold_we === 1'b1) begin
        n++;
        `CHK(k, n - 1)
        `CHK(hold_addr, dest + DEST_W'(n - 1))
        `CHK(hold_data, exp_word(n))
        `CHK(done, 1'(n == exp_n))
        `CHK(busy, 1'(n != exp_n))
      end
    end
    `CHK(n, exp_n)
    @(posedge mclk);
    #1;
    `CHK({busy, done, hold_we}, 3'b000)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // word 1 under several condition mixes, stop masking single sweep included
  task automatic test_conditions();
    logic [7:0] pats [4];
    pats = '{8'hFF, 8'h00, 8'hA5, 8'h5A};
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      cond <= pats[i];
      if (i == 0) begin
        run_copy(16'h0064, 8'h01, 1);
      end else begin
        run_copy(16'h0064 + DEST_W'(i * 4), 8'h02, 2);
      end
    end
  endtask

  // whole table, requested once the previous copy is back in idle
  task automatic test_full_table();
    run_copy(16'h02BC, 8'hB8, 184);
  endtask

  // a zero count is clamped up to one word, an oversize count down to the table
  task automatic test_count_floor();
    run_copy(16'h1000, 8'h00, 1);
    run_copy(16'h2000, 8'hFF, 184);
  endtask

  // ce low after the first write: outputs stand, then the copy resumes
  task automatic test_ce_freeze();
    int n;
    @(posedge mclk);
    req        <= 1'b1;
    dest_start <= 16'h3000;
    word_count <= 8'h03;
    @(posedge mclk);
    req <= 1'b0;
    @(posedge mclk);
    ce <= 1'b0;
    #1;
    `CHK({hold_we, hold_addr, hold_data}, {1'b1, 16'h3000, exp_word(1)})
    repeat (2) @(posedge mclk);
    ce <= 1'b1;
    #1;
    `CHK({busy, hold_we, hold_addr, hold_data}, {2'b11, 16'h3000, exp_word(1)})
    for (n = 2; n <= 3; n++) begin
      @(posedge mclk);
      #1;
      `CHK({done, hold_we, hold_addr}, {1'(n == 3), 1'b1, 16'h3000 + 16'(n - 1)})
      `CHK(hold_data, exp_word(n))
    end
    @(posedge mclk);
    #1;
    `CHK({busy, done, hold_we}, 3'b000)
  endtask

  // reset in mid-copy silences the outputs, and the next copy runs clean
  task automatic test_mid_reset();
    @(posedge mclk);
    req        <= 1'b1;
    dest_start <= 16'h4000;
    word_count <= 8'h05;
    @(posedge mclk);
    req <= 1'b0;
    repeat (2) @(posedge mclk);
    reset <= 1'b1;
    @(posedge mclk);
    reset <= 1'b0;
    #1;
    `CHK({busy, done, hold_we, hold_addr, hold_data}, 35'h0)
    run_copy(16'h4000, 8'h02, 2);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog: a hang counts as a mismatch
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails++;
      conclude();
    end
  end

  initial begin
    fails = 0;
    num_checks = 0;
    reset = 1'b1;
    ce = 1'b1;
    req = 1'b0;
    dest_start = '0;
    word_count = 8'h01;
    cond = 8'h00;
    for (int i = 0; i < 10; i++) ctrl_other[i*WORD_W +: WORD_W] = 16'hA000 | 16'(i);
    for (int i = 0; i < 4; i++) io_health[i*WORD_W +: WORD_W] = 16'h5100 | 16'(i);
    for (int i = 0; i < 3; i++) global_health[i*WORD_W +: WORD_W] = 16'h3C00 | 16'(i);
    repeat (11) @(posedge mclk);
    #1;
    // outputs quiet while reset is held
    `CHK({busy, done, hold_we, hold_addr, hold_data}, 35'h0)
    @(posedge mclk);
    reset <= 1'b0;
    test_conditions();
    test_full_table();
    test_count_floor();
    test_ce_freeze();
    test_mid_reset();
    conclude();
  end
endmodule
`default_nettype wire
